// file: design/mlc_desc_word.sv
// builds one module description word
// assumes per-module attributes come from the local bus scan logic
`timescale 1ns/1ps
`include "mlc_cfg.svh"
module mlc_desc_word
  import mlc_pkg::*;
(
  input wire logic present,
  input wire logic digital,
  input wire logic has_in,
  input wire logic has_out,
  input wire logic [6:0] size_bits,
  input wire logic [15:0] item_no,
  output mlc_word_t word
);
  always_comb begin
    word = '0;
    if (present) begin
      if (digital) begin
        // bit coded word replaces the item number
        word[`MLC_BIT_IN] = has_in;
        word[`MLC_BIT_OUT] = has_out;
        word[`MLC_SIZE_MSB:`MLC_SIZE_LSB] = size_bits;
        word[`MLC_BIT_DIG] = 1'b1;
      end else begin
        word = item_no;
      end
    end
  end
endmodule

// file: design/mlc_key_check.sv
// decides whether a written word is a command key
// assumes data and address are qualified by the write strobe upstream
`timescale 1ns/1ps
`include "mlc_cfg.svh"
module mlc_key_check
  import mlc_pkg::*;
(
  input mlc_word_t wdata,
  input wire logic fac_only,
  output logic key_ok
);
  always_comb begin
    // factory restore accepts the second key only
    if (fac_only) begin
      key_ok = (wdata == `MLC_KEY_B);
    end else begin
      key_ok = (wdata == `MLC_KEY_A) || (wdata == `MLC_KEY_B);
    end
  end
endmodule

// file: design/mlc_regs.sv
// module list tables and command registers
// assumes a protocol engine on ref_clk presents one word access per req pulse,
// and a scan engine loads module attributes by number
`timescale 1ns/1ps
`include "mlc_cfg.svh"

module mlc_regs
  import mlc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] fw_version,
  input wire logic scan_we,
  input wire logic [7:0] scan_num,
  input wire logic scan_digital,
  input wire logic scan_in,
  input wire logic scan_out,
  input wire logic [6:0] scan_size,
  input wire logic [15:0] scan_item,
  input wire logic [7:0] mod_count,
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [6:0] req_index,
  input wire logic [6:0] req_count,
  input wire logic [15:0] req_wdata,
  output logic ack,
  output logic req_err,
  output logic [15:0] rdata,
  output logic soft_reset,
  output logic flash_format,
  output logic extract_files,
  output logic factory_restore
);
  // ************************************
  // module attribute store
  // ************************************
  // what the scan engine reported for one module number
  typedef struct packed {
    logic present;
    logic digital;
    logic has_in;
    logic has_out;
    logic [6:0] size_bits;
    mlc_word_t item_no;
  } mlc_attr_s;

  // one entry per module number, kept outside the state struct as a memory
  mlc_attr_s attr_mem [0:255];

  always_ff @(posedge ref_clk) begin
    if (scan_we) begin
      attr_mem[scan_num] <= '{present: 1'b1, digital: scan_digital, has_in: scan_in,
        has_out: scan_out, size_bits: scan_size, item_no: scan_item};
    end
  end

  // ************************************
  // state
  // ************************************
  typedef struct packed {
    mlc_state_e st;
    logic ack;
    logic err;
    logic [15:0] rdata;
    logic [7:0] mod_num;
    logic rst;
    logic fmt;
    logic ext;
    logic fac;
  } mlc_state_s;

  mlc_state_s cur_ff;
  mlc_state_s nxt_cur;

  mlc_attr_s attr_rd;
  logic in_range;
  mlc_word_t word_rd;
  logic key_ok;
  logic tbl3_hit;
  logic tbl4_hit;
  logic [7:0] tbl_num;

  assign attr_rd = attr_mem[cur_ff.mod_num];
  assign in_range = (cur_ff.mod_num <= mod_count) && (cur_ff.mod_num != 8'h00);

  mlc_desc_word u_desc (
    .present(in_range && attr_rd.present),
    .digital(attr_rd.digital),
    .has_in(attr_rd.has_in),
    .has_out(attr_rd.has_out),
    .size_bits(attr_rd.size_bits),
    .item_no(attr_rd.item_no),
    .word(word_rd)
  );

  mlc_key_check u_key (
    .wdata(req_wdata),
    .fac_only(req_addr == `MLC_ADDR_FAC),
    .key_ok(key_ok)
  );

  // index runs 0 to count-1 within one request, so the count alone bounds the table
  assign tbl3_hit = (req_addr == `MLC_ADDR_TBL3) && (req_index < req_count)
    && (req_count <= `MLC_TBL3_LEN);
  assign tbl4_hit = (req_addr == `MLC_ADDR_TBL4) && (req_index < req_count)
    && (req_count <= `MLC_TBL4_LEN);
  // word i of a table is the module attached in position first + i
  assign tbl_num = (req_addr == `MLC_ADDR_TBL3) ?
    `MLC_TBL3_FIRST + {1'b0, req_index} : `MLC_TBL4_FIRST + {1'b0, req_index};

  // ************************************
  // next state
  // ************************************
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.ack = 1'b0;
    nxt_cur.rst = 1'b0;
    nxt_cur.fmt = 1'b0;
    nxt_cur.ext = 1'b0;
    nxt_cur.fac = 1'b0;
    unique case (cur_ff.st)
      MLC_IDLE: begin
        if (req) begin
          nxt_cur.err = 1'b0;
          if (!req_write) begin
            if (tbl3_hit || tbl4_hit) begin
              nxt_cur.mod_num = tbl_num;
              nxt_cur.st = MLC_READ;
            end else begin
              nxt_cur.err = 1'b1;
              nxt_cur.rdata = 16'h0000;
              nxt_cur.st = MLC_DONE;
            end
          end else begin
            nxt_cur.st = MLC_DONE;
            // write-only registers give no read data back
            nxt_cur.rdata = 16'h0000;
            // non-key writes start no command pulse; they still clear rdata and end with an ack
            unique case (req_addr)
              `MLC_ADDR_RST: nxt_cur.rst = key_ok;
              `MLC_ADDR_FMT: nxt_cur.fmt = key_ok && (fw_version >= `MLC_FW_FMT_MIN);
              `MLC_ADDR_EXT: nxt_cur.ext = key_ok && (fw_version >= `MLC_FW_FMT_MIN);
              `MLC_ADDR_FAC: nxt_cur.fac = key_ok && (fw_version >= `MLC_FW_FAC_MIN);
              default: nxt_cur.err = 1'b1;
            endcase
          end
        end
      end
      MLC_READ: begin
        // past the last module the word reads zero
        nxt_cur.rdata = word_rd;
        nxt_cur.st = MLC_DONE;
      end
      MLC_DONE: begin
        nxt_cur.ack = 1'b1;
        nxt_cur.st = MLC_IDLE;
      end
      default: nxt_cur.st = MLC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur_ff <= '{st: MLC_IDLE, rdata: 16'h0000, mod_num: 8'h00, default: 1'b0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign ack = cur_ff.ack;
  assign req_err = cur_ff.err;
  assign rdata = cur_ff.rdata;
  assign soft_reset = cur_ff.rst;
  assign flash_format = cur_ff.fmt;
  assign extract_files = cur_ff.ext;
  assign factory_restore = cur_ff.fac;
endmodule

// file: inc/mlc_cfg.svh
// constants of the module list and command register bank
// assumes word addressing as seen by the holding-register access port
`ifndef MLC_CFG_SVH
`define MLC_CFG_SVH

`define MLC_ADDR_TBL3 16'h2032
`define MLC_ADDR_TBL4 16'h2033
`define MLC_ADDR_RST 16'h2040
`define MLC_ADDR_FMT 16'h2041
`define MLC_ADDR_EXT 16'h2042
`define MLC_ADDR_FAC 16'h2043
`define MLC_KEY_A 16'hAA55
`define MLC_KEY_B 16'h55AA
`define MLC_TBL3_FIRST 8'h81
`define MLC_TBL4_FIRST 8'hC1
`define MLC_TBL3_LEN 7'h40
`define MLC_TBL4_LEN 7'h3F
`define MLC_MAX_MOD 8'hFF
`define MLC_FW_FMT_MIN 16'h0003
`define MLC_FW_FAC_MIN 16'h0009
`define MLC_BIT_IN 0
`define MLC_BIT_OUT 1
`define MLC_SIZE_LSB 8
`define MLC_SIZE_MSB 14
`define MLC_BIT_DIG 15

`endif

// file: inc/mlc_pkg.sv
// types of the module list and command register bank
// assumes mlc_cfg.svh is on the include path
package mlc_pkg;
  typedef logic [15:0] mlc_word_t;
  typedef logic [7:0] mlc_modnum_t;

  typedef enum logic [1:0] {
    MLC_IDLE = 2'b00,
    MLC_READ = 2'b01,
    MLC_DONE = 2'b11
  } mlc_state_e;
endpackage

// file: testbench/mlc_master.sv
// model of the remote master issuing one word access per request
// assumes the bank answers each access with an ack pulse
`timescale 1ns/1ps
module mlc_master (
  input wire logic ref_clk,
  input wire logic ack,
  output logic req,
  output logic req_write,
  output logic [15:0] req_addr,
  output logic [6:0] req_index,
  output logic [6:0] req_count,
  output logic [15:0] req_wdata
);
  initial begin
    {req, req_write, req_addr, req_index, req_count, req_wdata} = '0;
  end
  task acc(input logic w, input logic [15:0] a, input logic [6:0] i, input logic [6:0] c,
    input logic [15:0] d);
    int k;
    @(negedge ref_clk);
    {req, req_write, req_addr, req_index, req_count, req_wdata} = {1'b1, w, a, i, c, d};
    @(negedge ref_clk);
    req = 1'b0;
    // released address and data lines show the inverted value, not the old one
    req_addr = ~a;
    req_wdata = ~d;
    k = 0;
    while (ack !== 1'b1 && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
  endtask
endmodule

// file: testbench/mlc_regs_asserts.sv
// timing checks on the register bank ports
// assumes it is bound to every mlc_regs instance
`timescale 1ns/1ps
module mlc_regs_asserts (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] fw_version,
  input wire logic req,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [6:0] req_index,
  input wire logic [6:0] req_count,
  input wire logic [15:0] req_wdata,
  input wire logic ack,
  input wire logic req_err,
  input wire logic [15:0] rdata,
  input wire logic soft_reset,
  input wire logic flash_format,
  input wire logic extract_files,
  input wire logic factory_restore
);
  logic key;
  logic rd_ok;
  assign key = req_wdata == 16'hAA55 || req_wdata == 16'h55AA;
  assign rd_ok = !req_write && req_index < req_count
    && (req_addr == 16'h2032 && req_count <= 7'h40
    || req_addr == 16'h2033 && req_count <= 7'h3F);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_wr(a);
    req && req_write && req_addr == a;
  endsequence
  sequence s_done(e);
    !ack ##1 ack && req_err == e;
  endsequence
  a_reset_key: assert property (s_wr(16'h2040) ##0 key |=> soft_reset)
    else $error("no reset pulse");
  a_format_key: assert property (s_wr(16'h2041) ##0 key && fw_version >= 16'h0003
    |=> flash_format) else $error("no format pulse");
  a_extract_key: assert property (s_wr(16'h2042) ##0 key && fw_version >= 16'h0003
    |=> extract_files) else $error("no extract pulse");
  a_extract_old_fw: assert property (s_wr(16'h2042) ##0 fw_version < 16'h0003
    |=> !extract_files) else $error("extract on old firmware");
  a_factory_key: assert property (s_wr(16'h2043) ##0 req_wdata == 16'h55AA
    && fw_version >= 16'h0009 |=> factory_restore) else $error("no restore pulse");
  a_bad_key_quiet: assert property (req && req_write && !key
    |=> !(soft_reset || flash_format || extract_files || factory_restore))
    else $error("pulse on bad key");
  a_read_ack_time: assert property (req && rd_ok |=> !ack ##1 s_done(1'b0))
    else $error("read ack late");
  a_write_ack_time: assert property (req && req_write && req_addr[15:2] == 14'h0810
    |=> s_done(1'b0) ##0 rdata == 16'h0000) else $error("write ack wrong");
  a_unmapped_err: assert property (req && (req_addr < 16'h2032 || req_addr > 16'h2043)
    |=> s_done(1'b1) ##0 rdata == 16'h0000) else $error("no error on unmapped");
endmodule
bind mlc_regs mlc_regs_asserts u_chk (.*);

// file: testbench/test_module_list_and_command_regs.sv
// self-checking bench for the module list and command registers
// assumes the master model drives all access ports
`timescale 1ns/1ps
module test_module_list_and_command_regs;
  logic ref_clk = 1'b0;
  logic rstn, scan_we, scan_digital, scan_in, scan_out;
  logic [15:0] fw_version, scan_item, req_addr, req_wdata, rdata;
  logic [7:0] scan_num, mod_count;
  logic [6:0] scan_size, req_index, req_count;
  logic req, req_write, ack, req_err, soft_reset, flash_format, extract_files, factory_restore;
  int n_fail = 0;
  int compares = 0;
  // one nibble of pulse count per command output
  logic [15:0] np = 16'h0000;
  logic [15:0] b;
  mlc_regs dut (.*);
  mlc_master m (.*);
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) np <= np + {3'h0, factory_restore, 3'h0, extract_files, 3'h0,
    flash_format, 3'h0, soft_reset};
  task chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, s, e);
    end
  endtask
  task results;
    if (n_fail == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task ld(input logic [7:0] n, input logic [2:0] f, input logic [6:0] sz, input logic [15:0] it);
    @(negedge ref_clk);
    {scan_we, scan_num, scan_digital, scan_in, scan_out, scan_size, scan_item} =
      {1'b1, n, f, sz, it};
    @(negedge ref_clk);
    scan_we = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [6:0] i, c, input logic [15:0] e, er);
    m.acc(1'b0, a, i, c, 16'h0000);
    chk(rdata, e);
    chk({15'h0000, req_err}, er);
    chk({15'h0000, ack}, 16'h0001);
  endtask
  task wr(input logic [15:0] a, d, e);
    b = np;
    m.acc(1'b1, a, 7'h00, 7'h01, d);
    chk(np - b, e);
    chk({15'h0000, req_err}, 16'h0000);
    chk({15'h0000, ack}, 16'h0001);
  endtask
  // ********
  // scenarios
  // ********
  task t_tables;
    ld(8'h81, 3'b110, 7'h08, 16'hFFFF);
    ld(8'h82, 3'b101, 7'h02, 16'hFFFF);
    ld(8'h83, 3'b011, 7'h05, 16'h0123);
    ld(8'hC0, 3'b101, 7'h7F, 16'hFFFF);
    ld(8'hC1, 3'b111, 7'h10, 16'hFFFF);
    ld(8'hC2, 3'b110, 7'h01, 16'hFFFF);
    rd(16'h2032, 7'h00, 7'h03, 16'h8801, 16'h0000);
    rd(16'h2032, 7'h01, 7'h03, 16'h8202, 16'h0000);
    rd(16'h2032, 7'h02, 7'h03, 16'h0123, 16'h0000);
    rd(16'h2032, 7'h3F, 7'h40, 16'hFF02, 16'h0000);
    rd(16'h2033, 7'h00, 7'h02, 16'h9003, 16'h0000);
    rd(16'h2033, 7'h01, 7'h02, 16'h0000, 16'h0000);
    rd(16'h2032, 7'h00, 7'h41, 16'h0000, 16'h0001);
    rd(16'h2033, 7'h00, 7'h40, 16'h0000, 16'h0001);
    rd(16'h2050, 7'h00, 7'h01, 16'h0000, 16'h0001);
  endtask
  task t_keys;
    wr(16'h2040, 16'hAA55, 16'h0001);
    wr(16'h2040, 16'h55AA, 16'h0001);
    wr(16'h2041, 16'hAA55, 16'h0010);
    wr(16'h2042, 16'h55AA, 16'h0100);
    wr(16'h2043, 16'h55AA, 16'h1000);
    wr(16'h2043, 16'hAA55, 16'h0000);
    wr(16'h2040, 16'h55AB, 16'h0000);
  endtask
  task t_fw_gate;
    fw_version = 16'h0002;
    wr(16'h2041, 16'hAA55, 16'h0000);
    wr(16'h2042, 16'hAA55, 16'h0000);
    fw_version = 16'h0008;
    wr(16'h2043, 16'h55AA, 16'h0000);
    wr(16'h2042, 16'hAA55, 16'h0100);
  endtask
  // mid-run reset clears every output; the table store keeps its contents
  task t_reset;
    rd(16'h2032, 7'h00, 7'h01, 16'h8801, 16'h0000);
    @(negedge ref_clk);
    rstn = 1'b0;
    @(negedge ref_clk);
    chk(rdata, 16'h0000);
    b = {10'h000, ack, req_err, soft_reset, flash_format, extract_files, factory_restore};
    chk(b, 16'h0000);
    rstn = 1'b1;
    wr(16'h2040, 16'hAA55, 16'h0001);
    rd(16'h2032, 7'h01, 7'h02, 16'h8202, 16'h0000);
  endtask
  initial begin
    {rstn, fw_version, scan_we, mod_count} = {1'b0, 16'h0009, 1'b0, 8'hC1};
    {scan_num, scan_digital, scan_in, scan_out, scan_size, scan_item} = '0;
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    t_tables;
    t_keys;
    t_fw_gate;
    t_reset;
    results;
  end
  initial begin
    #20000;
    n_fail++;
    results;
  end
endmodule
